// ==== hw/mdsg_glue.sv ====
// Sequencing glue for optional multiply/divide, bit-test and skip-equal.
// Assumes host supplies synchronous register compares and cycle decodes.
`timescale 1ns/1ps
module mdsg_glue (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire mdsg_pkg::mdsg_in_t i_host,
  output mdsg_pkg::mdsg_out_t o_ctl
);
  import mdsg_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // State counters mirror the host's stepping stages; the host sees
  // them only through the registered outputs.
  logic div_state_ff_one_q;
  logic div_state_ff_two_q;
  logic div_state_two_buffered_q;
  logic div_state_ff_three_q;
  logic mul_state_ff_one_q;
  logic mul_state_ff_two_q;
  logic mul_state_ff_three_q;
  logic skip_state_one_q;
  logic skip_state_two_q;
  logic skip_state_three_q;
  logic [3:0] shift_count_q;
  logic stored_sign_bit_q;
  logic correction_flag_q;
  logic quotient_bit_q;
  logic overflow_q;
  mdsg_phase_t phase_q;
  mdsg_out_t out_q;

  // ----------------------------------------------------------------
  // Combinational terms
  // ----------------------------------------------------------------
  // Decoded terms, some built from other terms, from the state and host inputs
  logic penultimate_shift_state;
  logic final_shift_state;
  logic shift_advance_term;
  logic div_end_gate;
  logic div_seed_term;
  logic div_entry_term;
  logic div_inhibit_term;
  logic dividend_remainder_sign_match;
  logic div_ovf_one;
  logic div_ovf_two;
  logic div_one_set;
  logic div_two_set;
  logic div_three_set;
  logic mul_one_set;
  logic mul_two_set;
  logic mul_start;
  logic skip_counter_k_enable;
  logic skip_counter_k;
  logic mul_operand_sign_cond;
  logic overflow_set_strobe;
  logic sign_load;
  logic sign_value;
  logic correction_flag_set;

  // Shift-state decodes from the counter
  // Final implies penultimate, so clear-high needs the final decode off
  assign penultimate_shift_state = &shift_count_q[3:1];
  assign final_shift_state = &shift_count_q;
  assign shift_advance_term = div_state_ff_one_q
    & ~div_state_ff_two_q;

  // Divide state counter set terms
  // Seed and inhibit key on operand cycle six; a step there would reseed
  assign div_end_gate = div_state_ff_three_q
    & ~final_shift_state;
  assign div_seed_term = i_host.operand_cycle_six & div_state_ff_two_q;
  assign div_entry_term = i_host.operand_cycle_five
    & i_host.divide_active;
  assign div_inhibit_term = ~i_host.operand_cycle_six
    | ~div_state_ff_one_q;
  assign div_one_set = div_end_gate | div_seed_term;
  assign div_two_set = div_entry_term | ~div_state_ff_one_q;
  assign div_three_set = div_inhibit_term & div_state_ff_two_q;

  // Overflow detection; sign match is an equivalence, not a parity
  assign dividend_remainder_sign_match =
    ~(stored_sign_bit_q ^ i_host.partial_sign_bit);
  assign div_ovf_one = i_host.low_reg_zero & i_host.acc_matches_operand
    & div_state_two_buffered_q & div_state_ff_one_q;
  assign div_ovf_two = dividend_remainder_sign_match
    & div_state_ff_two_q & div_state_ff_one_q;
  // Strobe on a step taken while div state one is set and either overflow term is up, whether or not it then drops
  assign overflow_set_strobe = div_state_ff_one_q
    & i_host.shift_step & (div_ovf_one | div_ovf_two);

  // Multiply sequence terms
  // Multiply ff three just trails ff two by one step
  assign mul_start = i_host.operand_cycle_five
    & i_host.multiply_active;
  assign mul_one_set = final_shift_state & mul_state_ff_three_q;
  assign mul_two_set = mul_start | ~mul_state_ff_one_q;
  assign mul_operand_sign_cond = i_host.divisor_sign & stored_sign_bit_q;

  // Skip counter K term
  // Under a bit test, K stops once state three has set
  assign skip_counter_k_enable = ~i_host.bit_test_decode
    | ~skip_state_three_q;
  assign skip_counter_k = skip_counter_k_enable & skip_state_two_q;

  // Sign storage source select
  // Divide decode wins if both decodes are up in the same cycle
  assign sign_load = i_host.operand_cycle_four
    & (i_host.divide_active | i_host.multiply_active);
  assign sign_value = i_host.divide_active ? i_host.high_reg_top_bit
    : i_host.low_reg_top_bit;

  // Negative dividend correction: equal compare with a negative dividend
  assign correction_flag_set = i_host.acc_matches_operand & stored_sign_bit_q
    & div_state_ff_three_q;

  // ----------------------------------------------------------------
  // Sequencer phase, used to gate state advance per operation
  // ----------------------------------------------------------------
  // Only an entry term leaves idle, so stray steps are ignored
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_q <= MDSG_IDLE;
    end else begin
      case (phase_q)
        MDSG_IDLE: begin
          if (div_entry_term) begin
            phase_q <= MDSG_DIV;
          end else if (mul_start) begin
            phase_q <= MDSG_MUL;
          end
        end
        MDSG_DIV: begin
          if (final_shift_state && div_state_ff_three_q
              && i_host.shift_step) begin
            phase_q <= MDSG_IDLE;
          end
        end
        MDSG_MUL: begin
          if (final_shift_state && mul_state_ff_three_q
              && i_host.shift_step) begin
            phase_q <= MDSG_IDLE;
          end
        end
        default: phase_q <= MDSG_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Divide state counter: JK-style, loads set terms on each step
  // ----------------------------------------------------------------
  // Limitation: a sequence the host stops stepping early stays in its
  // phase until reset; the host must run a started operation out.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_state_ff_one_q <= RST_FF;
      div_state_ff_two_q <= RST_FF;
      div_state_two_buffered_q <= RST_FF;
      div_state_ff_three_q <= RST_FF;
    end else if (phase_q == MDSG_IDLE && !div_entry_term) begin
      div_state_ff_one_q <= RST_FF;
      div_state_ff_two_q <= RST_FF;
      div_state_two_buffered_q <= RST_FF;
      div_state_ff_three_q <= RST_FF;
    end else if (i_host.shift_step || div_entry_term) begin
      div_state_ff_one_q <= div_one_set;
      div_state_ff_two_q <= div_two_set;
      div_state_two_buffered_q <= div_two_set;
      div_state_ff_three_q <= div_three_set;
    end
  end

  // ----------------------------------------------------------------
  // Multiply state counter
  // ----------------------------------------------------------------
  // Cleared while idle so a new multiply always starts from a known state
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mul_state_ff_one_q <= RST_FF;
      mul_state_ff_two_q <= RST_FF;
      mul_state_ff_three_q <= RST_FF;
    end else if (phase_q == MDSG_IDLE && !mul_start) begin
      mul_state_ff_one_q <= RST_FF;
      mul_state_ff_two_q <= RST_FF;
      mul_state_ff_three_q <= RST_FF;
    end else if (i_host.shift_step || mul_start) begin
      mul_state_ff_one_q <= mul_one_set;
      mul_state_ff_two_q <= mul_two_set;
      mul_state_ff_three_q <= mul_state_ff_two_q;
    end
  end

  // ----------------------------------------------------------------
  // Shift counter, advanced on each divide step with div ff one set and ff two clear, or each multiply step
  // ----------------------------------------------------------------
  // Saturates at the final state; extra steps there do not wrap
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      shift_count_q <= RST_SHIFT;
    end else if (phase_q == MDSG_IDLE) begin
      shift_count_q <= RST_SHIFT;
    end else if (i_host.shift_step && !final_shift_state
                 && (shift_advance_term || phase_q == MDSG_MUL)) begin
      shift_count_q <= shift_count_q + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Skip-equal / bit-test state counter
  // ----------------------------------------------------------------
  // Cleared whenever neither skip-equal nor bit test is decoded
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      skip_state_one_q <= RST_FF;
      skip_state_two_q <= RST_FF;
      skip_state_three_q <= RST_FF;
    end else if (!i_host.skip_equal_instr && !i_host.bit_test_decode) begin
      skip_state_one_q <= RST_FF;
      skip_state_two_q <= RST_FF;
      skip_state_three_q <= RST_FF;
    end else begin
      skip_state_one_q <= 1'b1;
      skip_state_two_q <= skip_state_one_q;
      skip_state_three_q <= skip_counter_k | skip_state_three_q;
    end
  end

  // ----------------------------------------------------------------
  // Sign storage, correction, quotient bit and overflow flags
  // ----------------------------------------------------------------
  // Sign is captured once per divide or multiply, in operand cycle four
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stored_sign_bit_q <= RST_FF;
    end else if (sign_load) begin
      stored_sign_bit_q <= sign_value;
    end
  end

  // Correction holds until the next divide starts
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      correction_flag_q <= RST_FF;
    end else if (correction_flag_set) begin
      correction_flag_q <= 1'b1;
    end else if (div_entry_term) begin
      correction_flag_q <= RST_FF;
    end
  end

  // Quotient bit resamples on every cycle of div state three
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      quotient_bit_q <= RST_FF;
    end else if (div_state_ff_three_q) begin
      quotient_bit_q <= ~(i_host.divisor_sign
        ^ i_host.partial_sign_bit);
    end
  end

  // Set wins over the clear at a new divide entry; division still runs
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      overflow_q <= RST_FF;
    end else if (overflow_set_strobe) begin
      overflow_q <= 1'b1;
    end else if (div_entry_term) begin
      overflow_q <= RST_FF;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  // Each output is its term one clock late; the latency buys the host
  // glitch-free levels at the cost of one cycle on every decode.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_q <= '0;
    end else begin
      out_q.div_ovf_one <= div_ovf_one;
      out_q.div_ovf_two <= div_ovf_two;
      out_q.overflow <= overflow_q;
      out_q.skip_req <= i_host.skip_equal_instr
        & i_host.acc_matches_operand;
      out_q.skip_jump_one <= i_host.operand_cycle_six
        & i_host.skip_equal_instr & i_host.acc_matches_operand;
      out_q.penultimate_shift_state <= penultimate_shift_state;
      out_q.final_shift_state <= final_shift_state;
      out_q.shift_advance_term <= shift_advance_term;
      out_q.div_end_gate <= div_end_gate;
      out_q.clear_high_reg <= penultimate_shift_state & ~final_shift_state
        & i_host.correction_clear_cond;
      out_q.quotient_incr <= correction_flag_q & div_state_ff_two_q
        & final_shift_state;
      out_q.neg_div_correction_flag <= correction_flag_q;
      out_q.mul_overflow <= final_shift_state & mul_state_ff_two_q
        & i_host.partial_sign_bit & mul_operand_sign_cond;
      out_q.arith_exit <= div_state_ff_three_q
        | ~mul_state_ff_three_q;
      out_q.bit_test_zero_ok <= i_host.bit_test_enable
        & i_host.tested_bit_zero & i_host.polarity_zero;
      out_q.adder_skip_incr <= div_state_ff_two_q | ~mul_state_ff_two_q
        | i_host.test_skip_exit;
      out_q.mul_start <= mul_start;
      out_q.skip_counter_k <= skip_counter_k;
      out_q.quotient_bit <= quotient_bit_q;
      out_q.stored_sign_bit <= stored_sign_bit_q;
    end
  end

  // Straight from the output flip-flops
  assign o_ctl = out_q;

endmodule : mdsg_glue

// ==== hw/mdsg_pkg.sv ====
// Package for the multiply/divide and bit-test/skip sequencing glue.
// Assumes a single processor clock; all operand values come from the host.
package mdsg_pkg;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_FF = 1'b0;
  localparam logic [3:0] RST_SHIFT = 4'h0;

  // ----------------------------------------------------------------
  // Sequencer phases used to clear and advance the state counters
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MDSG_IDLE = 3'b001,
    MDSG_DIV = 3'b010,
    MDSG_MUL = 3'b100
  } mdsg_phase_t;

  // Host-side status and decode inputs
  typedef struct packed {
    logic low_reg_zero;
    logic acc_matches_operand;
    logic skip_equal_instr;
    logic operand_cycle_four;
    logic operand_cycle_five;
    logic operand_cycle_six;
    logic divide_active;
    logic multiply_active;
    logic high_reg_top_bit;
    logic low_reg_top_bit;
    logic partial_sign_bit;
    logic divisor_sign;
    logic correction_clear_cond;
    logic bit_test_enable;
    logic bit_test_decode;
    logic tested_bit_zero;
    logic polarity_zero;
    logic test_skip_exit;
    logic shift_step;
  } mdsg_in_t;

  // Outputs toward the host control logic
  typedef struct packed {
    logic div_ovf_one;
    logic div_ovf_two;
    logic overflow;
    logic skip_req;
    logic skip_jump_one;
    logic penultimate_shift_state;
    logic final_shift_state;
    logic shift_advance_term;
    logic div_end_gate;
    logic clear_high_reg;
    logic quotient_incr;
    logic neg_div_correction_flag;
    logic mul_overflow;
    logic arith_exit;
    logic bit_test_zero_ok;
    logic adder_skip_incr;
    logic mul_start;
    logic skip_counter_k;
    logic quotient_bit;
    logic stored_sign_bit;
  } mdsg_out_t;

endpackage : mdsg_pkg

// ==== dv/mdsg_glue_assertions.sv ====
// Port-level assertions for the sequencing glue.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module mdsg_glue_chk (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire mdsg_pkg::mdsg_in_t i_host,
  input wire mdsg_pkg::mdsg_out_t o_ctl
);
  import mdsg_pkg::*;
  // ------------------------------------------------
  // Relations, each output one clock after its cause; stored sign, quotient bit, overflow and correction flag two
  // ------------------------------------------------
  mdsg_in_t h;
  mdsg_out_t o;
  logic entry;
  // Short aliases keep each property to two to four lines
  assign h = i_host;
  assign o = o_ctl;
  assign entry = h.operand_cycle_five & h.divide_active;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  chk_skip_req: assert property (
    o.skip_req == $past(h.skip_equal_instr & h.acc_matches_operand))
    else $error("skip request wrong");
  chk_skip_jump: assert property (o.skip_jump_one ==
    $past(h.operand_cycle_six & h.skip_equal_instr & h.acc_matches_operand))
    else $error("skip jump term wrong");
  chk_bit_zero: assert property (o.bit_test_zero_ok ==
    $past(h.bit_test_enable & h.tested_bit_zero & h.polarity_zero))
    else $error("bit test success wrong");
  chk_mul_start: assert property (
    o.mul_start == $past(h.operand_cycle_five & h.multiply_active))
    else $error("multiply start wrong");
  chk_final_penult: assert property (
    o.final_shift_state |-> o.penultimate_shift_state)
    else $error("final without penultimate");
  chk_clear_high: assert property (o.clear_high_reg |->
    o.penultimate_shift_state && !o.final_shift_state &&
    $past(h.correction_clear_cond)) else $error("clear high wrong");
  chk_end_gate: assert property (
    o.div_end_gate |-> !o.final_shift_state) else $error("end gate wrong");
  chk_adv_excl: assert property (o.shift_advance_term |->
    !(o.div_ovf_one || o.div_ovf_two)) else $error("advance overlap");
  chk_ovf_cause: assert property (o.div_ovf_one |->
    $past(h.low_reg_zero & h.acc_matches_operand))
    else $error("overflow term one wrong");
  chk_mul_ovf: assert property (o.mul_overflow |->
    o.final_shift_state && $past(h.partial_sign_bit & h.divisor_sign))
    else $error("multiply overflow wrong");
  chk_quot_incr: assert property (
    o.quotient_incr |-> o.final_shift_state) else $error("increment wrong");
  chk_exit_skip: assert property (
    $past(h.test_skip_exit) |-> o.adder_skip_incr)
    else $error("adder skip control wrong");
  // Sign reaches the pins two clocks after operand cycle four
  chk_div_sign: assert property ($past(h.operand_cycle_four &
    h.divide_active, 2) |->
    o.stored_sign_bit == $past(h.high_reg_top_bit, 2))
    else $error("dividend sign wrong");
  chk_mul_sign: assert property ($past(h.operand_cycle_four &
    h.multiply_active & !h.divide_active, 2) |->
    o.stored_sign_bit == $past(h.low_reg_top_bit, 2))
    else $error("multiplier sign wrong");
  chk_quot_bit: assert property (o.div_end_gate |=>
    o.quotient_bit == $past(!(h.divisor_sign ^ h.partial_sign_bit), 2))
    else $error("quotient bit wrong");
  chk_ovf_sticky: assert property ($fell(o.overflow) |->
    $past(entry) || $past(entry, 2)) else $error("overflow not sticky");
  cov_ovf: cover property ($rose(o.overflow));
  cov_final: cover property ($rose(o.final_shift_state));
  cov_jump: cover property (o.skip_jump_one);
  cov_mul: cover property (o.mul_start);
endmodule : mdsg_glue_chk

// ==== dv/mdsg_host_model.sv ====
// Host processor model: operand cycles, decodes and shift steps.
// Assumes the bench holds the steady status fields on i_static.
`timescale 1ns/1ps
module mdsg_host_model (
  input wire logic i_sys_clk,
  input wire logic i_go,
  input wire logic i_div,
  input wire logic i_slow,
  input wire mdsg_pkg::mdsg_in_t i_static,
  output mdsg_pkg::mdsg_in_t o_host
);
  import mdsg_pkg::*;
  // ------------------------------------------------
  // Instruction sequencing
  // ------------------------------------------------
  logic run_q = 1'b0;
  logic [7:0] cyc_q = 8'h00;
  // Falling edge, so the block always samples settled levels
  always @(negedge i_sys_clk) begin
    if (run_q) begin
      cyc_q <= cyc_q + 8'h01;
      run_q <= (cyc_q != 8'hC7);
    end else if (i_go) begin
      run_q <= 1'b1;
      cyc_q <= 8'h00;
    end
  end
  // Decodes hold for the whole instruction; slow mode steps every 4th
  always_comb begin
    o_host = i_static;
    if (run_q) begin
      o_host.divide_active = i_div;
      o_host.multiply_active = !i_div;
      o_host.operand_cycle_four = (cyc_q == 8'h01);
      o_host.operand_cycle_five = (cyc_q == 8'h02);
      o_host.operand_cycle_six = (cyc_q == 8'h03);
      o_host.shift_step = (cyc_q > 8'h03) &&
        (i_slow ? (cyc_q[1:0] == 2'h3) : cyc_q[0]);
    end
  end
endmodule : mdsg_host_model

// ==== dv/testbench.sv ====
// Self-checking bench for the sequencing glue.
// Assumes the host model drives every input except clock and reset.
`timescale 1ns/1ps
module testbench;
  import mdsg_pkg::*;
  // ------------------------------------------------
  // Clock, instances and scenarios
  // ------------------------------------------------
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic go = 1'b0;
  logic div = 1'b0;
  logic slow = 1'b0;
  mdsg_in_t stat = '0;
  mdsg_in_t host;
  mdsg_out_t ctl;
  mdsg_out_t seen;
  mdsg_out_t snap2;
  int fail_count = 0;
  int compares = 0;
  // 40 MHz processor clock
  initial begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  mdsg_host_model host_u (.i_sys_clk(i_sys_clk), .i_go(go), .i_div(div),
    .i_slow(slow), .i_static(stat), .o_host(host));
  mdsg_glue dut_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_host(host),
    .o_ctl(ctl));
  task automatic check(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic stop_test();
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic do_reset();
    stat = '0;
    i_rstn = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    check(ctl === '0, 1'b1, "outputs set in reset");
    i_rstn = 1'b1;
    @(negedge i_sys_clk);
    check(ctl.arith_exit, 1'b1, "idle exit term");
    check(ctl.adder_skip_incr, 1'b1, "idle skip control");
  endtask : do_reset
  // One whole instruction; records every output seen and one snapshot,
  // two clocks after operand cycle four, when its sign is on the pins
  task automatic run_seq(input logic d, input logic s);
    div = d;
    slow = s;
    seen = '0;
    go <= 1'b1;
    @(negedge i_sys_clk);
    go <= 1'b0;
    while (!host_u.run_q) @(negedge i_sys_clk);
    while (host_u.run_q) begin
      seen = mdsg_out_t'(seen | ctl);
      if (host_u.cyc_q == 8'h02) snap2 = ctl;
      @(negedge i_sys_clk);
    end
  endtask : run_seq
  task automatic t_skip();
    for (int k = 0; k < 8; k++) begin
      stat.skip_equal_instr = k[0];
      stat.acc_matches_operand = k[1];
      stat.operand_cycle_six = k[2];
      @(negedge i_sys_clk);
      check(ctl.skip_req, k[0] & k[1], "skip request");
      check(ctl.skip_jump_one, &k[2:0], "skip jump term");
    end
    stat = '0;
  endtask : t_skip
  task automatic t_bits();
    for (int k = 0; k < 8; k++) begin
      stat.bit_test_enable = k[0];
      stat.test_skip_exit = k[0];
      stat.tested_bit_zero = k[1];
      stat.bit_test_decode = k[1];
      stat.polarity_zero = k[2];
      @(negedge i_sys_clk);
      check(ctl.bit_test_zero_ok, &k[2:0], "bit test zero");
    end
    stat = '0;
    // Skip counter K under a bit test: one pulse once state two is reached
    @(negedge i_sys_clk);
    stat.bit_test_decode = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    check(ctl.skip_counter_k, 1'b1, "skip counter k missing");
    @(negedge i_sys_clk);
    check(ctl.skip_counter_k, 1'b0, "skip counter k stuck");
    stat = '0;
  endtask : t_bits
  // Sign storage and multiply start for both operations; shift states for multiply only
  task automatic t_sign();
    for (int k = 0; k < 4; k++) begin
      do_reset();
      stat.high_reg_top_bit = k[0] ? k[1] : !k[1];
      stat.low_reg_top_bit = k[0] ? !k[1] : k[1];
      stat.partial_sign_bit = !k[1];
      stat.divisor_sign = 1'b1;
      stat.correction_clear_cond = 1'b1;
      run_seq(k[0], k[1]);
      check(snap2.stored_sign_bit, k[1], "stored sign");
      check(snap2.mul_start, !k[0], "multiply start");
      check(ctl.overflow, 1'b0, "overflow without cause");
      if (!k[0]) begin
        check(seen.penultimate_shift_state, 1'b1, "no penultimate");
        check(seen.final_shift_state, 1'b1, "no final state");
      end
    end
  endtask : t_sign
  // Overflowing divide, then a clean slow divide must clear the flag
  task automatic t_div();
    do_reset();
    stat.low_reg_zero = 1'b1;
    stat.acc_matches_operand = 1'b1;
    stat.high_reg_top_bit = 1'b1;
    stat.partial_sign_bit = 1'b1;
    run_seq(1'b1, 1'b0);
    check(seen.div_ovf_one, 1'b1, "overflow term one");
    check(ctl.overflow, 1'b1, "overflow not kept");
    check(ctl.neg_div_correction_flag, 1'b1, "no negative dividend fix");
    check(seen.quotient_incr, 1'b1, "no quotient increment");
    stat.low_reg_zero = 1'b0;
    stat.acc_matches_operand = 1'b0;
    stat.partial_sign_bit = 1'b0;
    run_seq(1'b1, 1'b1);
    check(seen.div_ovf_two, 1'b0, "overflow term two");
    check(ctl.overflow, 1'b0, "overflow not cleared");
    check(ctl.neg_div_correction_flag, 1'b0, "correction not cleared");
  endtask : t_div
  initial begin
    do_reset();
    t_skip();
    t_bits();
    t_sign();
    t_div();
    stop_test();
  end
  // Whole run needs about 32 us
  initial begin
    #100us;
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end
endmodule : testbench
bind mdsg_glue mdsg_glue_chk chk_u (
  .i_sys_clk(i_sys_clk),
  .i_rstn(i_rstn),
  .i_host(i_host),
  .o_ctl(o_ctl)
);
